// ==== common/quife_pkg.sv ====
// constants shared by the quad uart interrupt front end
// Function
// (R1) snapshot and global views refresh only on acknowledge or update command, not request
// (R2) snapshot holds 3-bit byte count, 3-bit source type, 2-bit channel
// (R3) type codes: 000 none, 001 state, x10 tx, 011 rx, 100 break, 101 timer, 111 rx err
// (R4) receive types report bytes to read; transmit type reports free transmit bytes
// (R5) snapshot is read only at 28h; writes there change nothing
// (R6) read at 2Ah gives captured byte count in low three bits, upper bits zero
// (R7) receive window read without receiver cause returns all ones, pops nothing
// (R8) transmit window write without transmitter cause is ignored, no fifo changes
// (R9) with rx or tx cause, window reads pop and writes push that channel
// (R10) read at 29h returns captured channel code with six zero bits above
// (R11) timer interrupts report channel 01 for first pair, 11 for second pair
// (R12) six-bit threshold in control register gates request; resets to zero
// (R13) request asserted only while winning bid exceeds threshold
// (R14) vector style 00 base, 01 base high six plus channel, 10 adds type
// (R15) vector style 11 returns FF during acknowledge
// (R16) vector style resets to zero; control register read/write at 2Ch
// (R17) one bid priority register per channel at 20h-23h: break, state, timer fields
// (R18) bid priority fields reset to zero
// (R19) host must program bid priorities before relying on arbitration
// (R20) vector base write only at 29h; upper three bits in vector for styles 00 to 10
package quife_pkg;
  localparam logic [5:0] ADDR_BID0 = 6'h20;
  localparam logic [5:0] ADDR_SNAP = 6'h28;
  localparam logic [5:0] ADDR_CHAN_VEC = 6'h29;
  localparam logic [5:0] ADDR_COUNT_UPD = 6'h2A;
  localparam logic [5:0] ADDR_WINDOW = 6'h2B;
  localparam logic [5:0] ADDR_CTRL = 6'h2C;
  localparam logic [7:0] BID_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // field positions
  localparam int SNAP_CNT_LSB = 5;
  localparam int SNAP_TYPE_LSB = 2;
  localparam int CTRL_THR_LSB = 2;
  localparam int BID_BRK_LSB = 5;
  localparam int BID_COS_LSB = 2;
  // source type codes
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_STATE = 3'h1;
  localparam logic [2:0] TYPE_TX = 3'h2;
  localparam logic [2:0] TYPE_RX = 3'h3;
  localparam logic [2:0] TYPE_BREAK = 3'h4;
  localparam logic [2:0] TYPE_TIMER = 3'h5;
  localparam logic [2:0] TYPE_RX_ERR = 3'h7;
  // vector styles
  localparam logic [1:0] STYLE_BASE = 2'h0;
  localparam logic [1:0] STYLE_CHAN = 2'h1;
  localparam logic [1:0] STYLE_TYPE = 2'h2;
  localparam logic [1:0] STYLE_OFF = 2'h3;
  // fixed low bits of the rx and tx bids
  localparam logic [2:0] BID_RX_LOW = 3'h7;
  localparam logic [2:0] BID_TX_LOW = 3'h2;
endpackage : quife_pkg

// ==== rtl/quife_core.sv ====
// interrupt arbiter, snapshot, global windows and vector for four uarts
module quife_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic interrupt_ack_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic interrupt_request_n_out,
  output logic interrupt_request_n_oe,
  input wire logic [3:0] rx_ready,
  input wire logic [3:0] rx_error,
  input wire logic [3:0] tx_ready,
  input wire logic [3:0] break_change,
  input wire logic [3:0] state_change,
  input wire logic [1:0] timer_event,
  input wire logic [11:0] rx_count,
  input wire logic [11:0] tx_space,
  input wire logic [31:0] rx_data,
  output logic [3:0] rx_pop,
  output logic [3:0] tx_push,
  output logic [7:0] tx_data
);

  function automatic logic addr_is(input logic [5:0] a, input logic [5:0] o);
    addr_is = (a == o);
  endfunction

  function automatic logic is_rx(input logic [2:0] t);
    is_rx = (t[1:0] == 2'h3);
  endfunction

  function automatic logic is_tx(input logic [2:0] t);
    is_tx = (t[1:0] == 2'h2);
  endfunction

  // host pins: two flops each, then a third stage for edge detection
  logic [17:0] pin_s1_q;
  logic [17:0] pin_s2_q;
  logic [17:0] pin_s3_q;
  wire [17:0] pin_raw = {chip_sel_n, rd_n, wr_n, interrupt_ack_n, addr, data_in};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_q <= 18'h3C000;
      pin_s2_q <= 18'h3C000;
      pin_s3_q <= 18'h3C000;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // strobe decode on the synchronised copies
  wire [5:0] bus_addr = pin_s2_q[13:8];
  wire [7:0] bus_data = pin_s2_q[7:0];
  wire rd_act = !pin_s2_q[17] && !pin_s2_q[16];
  wire rd_was = !pin_s3_q[17] && !pin_s3_q[16];
  wire wr_act = !pin_s2_q[17] && !pin_s2_q[15];
  wire wr_was = !pin_s3_q[17] && !pin_s3_q[15];
  wire ack_act = !pin_s2_q[14];
  wire ack_start = ack_act && pin_s3_q[14];
  wire rd_start = rd_act && !rd_was;
  // write data is taken at strobe start; host must hold data valid with the strobe
  wire wr_start = wr_act && !wr_was;

  // registers
  logic [7:0] bid_q [4];
  logic [7:0] ctrl_q;
  logic [7:0] vec_q;
  logic [7:0] snap_q;
  logic irq_q;
  logic [7:0] data_q;
  logic [3:0] rx_pop_q;
  logic [3:0] tx_push_q;
  logic [7:0] tx_data_q;

  wire [5:0] thr = ctrl_q[7:quife_pkg::CTRL_THR_LSB];
  wire [1:0] style = ctrl_q[1:0];
  wire [1:0] snap_chan = snap_q[1:0];
  wire [2:0] snap_type = snap_q[4:quife_pkg::SNAP_TYPE_LSB];
  wire [2:0] snap_cnt = snap_q[7:quife_pkg::SNAP_CNT_LSB];
  wire snap_rx = is_rx(snap_type);
  wire snap_tx = is_tx(snap_type);

  // arbitration: highest bid wins; ties go to the source scanned first, channels 0 to 3 before the timers
  logic [5:0] win_bid;
  logic [2:0] win_type;
  logic [1:0] win_chan;
  logic [2:0] win_cnt;
  logic win_found;

  always_comb
  begin
    win_bid = 6'h00;
    win_type = quife_pkg::TYPE_NONE;
    win_chan = 2'h0;
    win_cnt = 3'h0;
    win_found = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (rx_ready[i] && (!win_found || {rx_count[i*3 +: 3], quife_pkg::BID_RX_LOW} > win_bid))
      begin
        win_bid = {rx_count[i*3 +: 3], quife_pkg::BID_RX_LOW};
        win_type = rx_error[i] ? quife_pkg::TYPE_RX_ERR : quife_pkg::TYPE_RX; // see R3
        win_chan = 2'(i);
        win_cnt = rx_count[i*3 +: 3]; // see R4
        win_found = 1'b1;
      end
      if (tx_ready[i] && (!win_found || {tx_space[i*3 +: 3], quife_pkg::BID_TX_LOW} > win_bid))
      begin
        win_bid = {tx_space[i*3 +: 3], quife_pkg::BID_TX_LOW};
        win_type = quife_pkg::TYPE_TX;
        win_chan = 2'(i);
        win_cnt = tx_space[i*3 +: 3]; // see R4
        win_found = 1'b1;
      end
      if (break_change[i] && (!win_found || {bid_q[i][7:5], 3'h0} > win_bid))
      begin
        win_bid = {bid_q[i][7:quife_pkg::BID_BRK_LSB], 3'h0}; // see R17
        win_type = quife_pkg::TYPE_BREAK;
        win_chan = 2'(i);
        win_cnt = 3'h0;
        win_found = 1'b1;
      end
      if (state_change[i] && (!win_found || {bid_q[i][4:2], 3'h0} > win_bid))
      begin
        win_bid = {bid_q[i][4:quife_pkg::BID_COS_LSB], 3'h0};
        win_type = quife_pkg::TYPE_STATE;
        win_chan = 2'(i);
        win_cnt = 3'h0;
        win_found = 1'b1;
      end
    end
    // timer pairs answer as channel 01 and 11, priority from that channel
    for (int k = 0; k < 2; k++)
    begin
      if (timer_event[k] && (!win_found || {bid_q[2*k+1][1:0], 4'h0} > win_bid))
      begin
        win_bid = {bid_q[2*k+1][1:0], 4'h0};
        win_type = quife_pkg::TYPE_TIMER;
        win_chan = {k[0], 1'b1}; // see R11
        win_cnt = 3'h0;
        win_found = 1'b1;
      end
    end
  end

  // request and snapshot load; no load from the request itself
  wire irq_d = win_found && (win_bid > thr); // see R13, R12
  wire snap_load = ack_start || (wr_start && addr_is(bus_addr, quife_pkg::ADDR_COUNT_UPD)); // see R1
  wire [7:0] snap_d = {win_cnt, win_type, win_chan}; // see R2

  // register writes; 28h has no storage to write, so writes there are dropped (see R5); a write at 2Ah loads the snapshot
  wire wr_bid = wr_start && (bus_addr[5:2] == quife_pkg::ADDR_BID0[5:2]); // see R17
  wire wr_ctrl = wr_start && addr_is(bus_addr, quife_pkg::ADDR_CTRL); // see R16
  wire wr_vec = wr_start && addr_is(bus_addr, quife_pkg::ADDR_CHAN_VEC); // see R20
  wire wr_win = wr_start && addr_is(bus_addr, quife_pkg::ADDR_WINDOW);
  wire rd_win = rd_start && addr_is(bus_addr, quife_pkg::ADDR_WINDOW);

  // acknowledge vector by style
  wire [7:0] vector =
    (style == quife_pkg::STYLE_BASE) ? vec_q : // see R14
    (style == quife_pkg::STYLE_CHAN) ? {vec_q[7:2], snap_chan} :
    (style == quife_pkg::STYLE_TYPE) ? {vec_q[7:5], snap_type, snap_chan} : // see R20
    quife_pkg::ALL_ONES; // see R15

  // read mux; the channel view is the snapshot, not a register of its own
  wire [7:0] rd_mux =
    (bus_addr[5:2] == quife_pkg::ADDR_BID0[5:2]) ? bid_q[bus_addr[1:0]] :
    addr_is(bus_addr, quife_pkg::ADDR_SNAP) ? snap_q :
    addr_is(bus_addr, quife_pkg::ADDR_CHAN_VEC) ? {6'h00, snap_chan} : // see R10
    addr_is(bus_addr, quife_pkg::ADDR_COUNT_UPD) ? {5'h00, snap_cnt} : // see R6
    addr_is(bus_addr, quife_pkg::ADDR_WINDOW) ?
      (snap_rx ? rx_data[snap_chan*8 +: 8] : quife_pkg::ALL_ONES) : // see R7
    addr_is(bus_addr, quife_pkg::ADDR_CTRL) ? ctrl_q : 8'h00;

  // acknowledge owns the bus over a read
  wire [7:0] data_d = ack_act ? vector : (rd_start ? rd_mux : data_q);

  // configuration registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
        bid_q[i] <= quife_pkg::BID_RESET; // see R18
      ctrl_q <= quife_pkg::CTRL_RESET; // see R12, R16
      vec_q <= quife_pkg::VEC_RESET;
    end
    else
    begin
      if (wr_bid)
        bid_q[bus_addr[1:0]] <= bus_data;
      if (wr_ctrl)
        ctrl_q <= bus_data;
      if (wr_vec)
        vec_q <= bus_data;
    end
  end

  // snapshot, request, read data and fifo strobes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      snap_q <= 8'h00;
      irq_q <= 1'b0;
      data_q <= 8'h00;
      rx_pop_q <= 4'h0;
      tx_push_q <= 4'h0;
      tx_data_q <= 8'h00;
    end
    else
    begin
      if (snap_load)
        snap_q <= snap_d;
      irq_q <= irq_d;
      data_q <= data_d;
      rx_pop_q <= (rd_win && snap_rx) ? (4'h1 << snap_chan) : 4'h0; // see R9, R7
      tx_push_q <= (wr_win && snap_tx) ? (4'h1 << snap_chan) : 4'h0; // see R9, R8
      if (wr_win && snap_tx)
        tx_data_q <= bus_data;
    end
  end

  // outputs; the request pin is open drain, pulled low while asserted
  assign data_out = data_q;
  assign data_oe = rd_act || ack_act;
  assign interrupt_request_n_out = 1'b0;
  assign interrupt_request_n_oe = irq_q;
  assign rx_pop = rx_pop_q;
  assign tx_push = tx_push_q;
  assign tx_data = tx_data_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_NO_REFRESH: assert property (!snap_load |=> $stable(snap_q)) // see R1
    else $error("snapshot changed without acknowledge or update");
  AST_SNAP_CAPTURE: assert property (ack_start |=> snap_q == $past(snap_d)) // see R2
    else $error("snapshot did not capture winner");
  AST_SNAP_RO: assert property (wr_start && addr_is(bus_addr, quife_pkg::ADDR_SNAP) && !ack_start
    |=> snap_q == $past(snap_q)) // see R5
    else $error("write altered snapshot");
  AST_COUNT_READ: assert property (rd_start && !ack_act
    && addr_is(bus_addr, quife_pkg::ADDR_COUNT_UPD) |=> data_q == {5'h00, $past(snap_cnt)}) // see R6
    else $error("byte count read wrong");
  AST_RX_EMPTY: assert property (rd_win && !ack_act && !snap_rx
    |=> data_q == 8'hFF && rx_pop == 4'h0) // see R7
    else $error("window read without receiver cause misbehaved");
  AST_TX_IGNORE: assert property (wr_win && !snap_tx |=> tx_push == 4'h0 ##1 tx_push == 4'h0) // see R8
    else $error("transmit write without cause pushed");
  AST_RX_POP: assert property (rd_win && snap_rx |=> rx_pop == (4'h1 << $past(snap_chan))
    ##1 rx_pop == 4'h0) // see R9
    else $error("receive pop wrong or not single");
  AST_IRQ_GATE: assert property (interrupt_request_n_oe // see R13
    |-> $past(win_found) && $past(win_bid) > $past(thr))
    else $error("request asserted at or below threshold");
  AST_VEC_OFF: assert property (ack_act && style == quife_pkg::STYLE_OFF |=> data_q == 8'hFF) // see R15
    else $error("disabled vector not all ones");
  AST_VEC_CHAN: assert property (ack_act && style == quife_pkg::STYLE_CHAN
    |=> data_q == {$past(vec_q[7:2]), $past(snap_chan)}) // see R14
    else $error("channel vector wrong");

endmodule // quife_core

// ==== verification/quife_host_model.sv ====
// host processor model driving the device's parallel register bus
module quife_host_model (
  input wire logic core_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic interrupt_ack_n,
  output logic [5:0] addr,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus drive state seen when the answer was taken
  logic oe_seen;

  // idle bus at time zero
  initial
  begin
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    interrupt_ack_n = 1'b1;
    addr = 6'h00;
    data_in = 8'h00;
  end

  // kind 0 read, 1 write, 2 acknowledge; strobes held 6 cycles low, 5 high
  // since the pins pass two sync flops and need at least 3 cycles each way
  task automatic strobe(input logic [5:0] a, input logic [7:0] d, input logic [1:0] kind,
                        output logic [7:0] q);
    @(posedge core_clk);
    #2;
    addr = a;
    data_in = d;
    chip_sel_n = (kind == 2'h2);
    rd_n = (kind != 2'h0);
    wr_n = (kind != 2'h1);
    interrupt_ack_n = (kind != 2'h2);
    repeat (6) @(posedge core_clk);
    #2;
    q = data_out;
    oe_seen = data_oe;
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    interrupt_ack_n = 1'b1;
    data_in = ~d; // released bus must not keep showing the old byte
    repeat (5) @(posedge core_clk);
    // callers then change device inputs off the sampling edge
    #2;
  endtask
endmodule // quife_host_model

// ==== verification/quad_uart_interrupt_front_end_test.sv ====
// self-checking testbench of the four-channel interrupt front end
module quad_uart_interrupt_front_end_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, nrst, chip_sel_n, rd_n, wr_n, interrupt_ack_n;
  logic [5:0] addr;
  logic [7:0] data_in, data_out, tx_data, pushed;
  logic data_oe, interrupt_request_n_out, interrupt_request_n_oe;
  logic [3:0] rx_ready, rx_error, tx_ready, break_change, state_change;
  logic [3:0] rx_pop, tx_push, pop_log, push_log;
  logic [1:0] timer_event;
  logic [11:0] rx_count, tx_space;
  logic [31:0] rx_data;
  int fails, checks;

  quife_core dut (.core_clk(core_clk), .nrst(nrst), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .interrupt_ack_n(interrupt_ack_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .interrupt_request_n_out(interrupt_request_n_out),
    .interrupt_request_n_oe(interrupt_request_n_oe), .rx_ready(rx_ready), .rx_error(rx_error),
    .tx_ready(tx_ready), .break_change(break_change), .state_change(state_change),
    .timer_event(timer_event), .rx_count(rx_count), .tx_space(tx_space), .rx_data(rx_data),
    .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data));
  quife_host_model host (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
    .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .interrupt_ack_n(interrupt_ack_n), .addr(addr),
    .data_in(data_in));

  // accumulate fifo strobes so one-cycle pulses are never missed
  always @(posedge core_clk)
  begin
    pop_log <= pop_log | rx_pop;
    push_log <= push_log | tx_push;
    if (|tx_push)
      pushed <= tx_data;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.strobe(a, 8'h00, 2'h0, q);
    check(q, exp);
    check({7'h00, host.oe_seen}, 8'h01);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.strobe(a, d, 2'h1, q);
    check({7'h00, host.oe_seen}, 8'h00);
  endtask

  task automatic ack_chk(input logic [7:0] exp);
    logic [7:0] q;
    host.strobe(6'h00, 8'h00, 2'h2, q);
    check(q, exp);
    check({7'h00, host.oe_seen}, 8'h01);
  endtask

  // the pin itself is only ever pulled low, so its level must stay 0
  task automatic irq_chk(input logic exp);
    repeat (4) @(posedge core_clk);
    #2;
    check({6'h00, interrupt_request_n_out, interrupt_request_n_oe}, {7'h00, exp});
  endtask

  task automatic print_verdict;
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // reset values, unmapped read and idle request
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      rd_chk(6'h20 + 6'(i), 8'h00);
    rd_chk(6'h2C, 8'h00);
    rd_chk(6'h2D, 8'h00);
    irq_chk(1'b0);
  endtask

  // receive interrupt on channel 2: threshold edge, snapshot, globals, pop
  task automatic t_rx;
    for (int i = 0; i < 4; i++)
      wr(6'h20 + 6'(i), 8'h00);
    rx_count = 12'h140;
    rx_data = 32'h005A0000;
    rx_ready = 4'h4;
    irq_chk(1'b1);
    wr(6'h2C, 8'hBC);
    irq_chk(1'b0);
    rd_chk(6'h2C, 8'hBC);
    wr(6'h2C, 8'hB8);
    irq_chk(1'b1);
    rd_chk(6'h28, 8'h00);
    wr(6'h29, 8'hA5);
    ack_chk(8'hA5);
    rd_chk(6'h28, 8'hAE);
    wr(6'h28, 8'hFF);
    rd_chk(6'h28, 8'hAE);
    rd_chk(6'h29, 8'h02);
    rd_chk(6'h2A, 8'h05);
    pop_log = 4'h0;
    push_log = 4'h0;
    rd_chk(6'h2B, 8'h5A);
    wr(6'h2B, 8'h11);
    check({pop_log, push_log}, 8'h40);
  endtask

  // the two vector styles that replace low base bits, and style off
  task automatic t_styles;
    logic [7:0] exp [3] = '{8'hA6, 8'hAE, 8'hFF};
    for (int s = 1; s < 4; s++)
    begin
      wr(6'h2C, {6'h2E, 2'(s)});
      ack_chk(exp[s-1]);
    end
  endtask

  // transmit interrupt via update command, window push and empty read
  task automatic t_tx;
    rx_ready = 4'h0;
    tx_space = 12'h018;
    tx_ready = 4'h2;
    wr(6'h2C, 8'h00);
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h69);
    rd_chk(6'h2A, 8'h03);
    pop_log = 4'h0;
    push_log = 4'h0;
    rd_chk(6'h2B, 8'hFF);
    wr(6'h2B, 8'h3C);
    check({pop_log, push_log}, 8'h02);
    check(pushed, 8'h3C);
  endtask

  // timer, break, state change and errored receive, each outbidding the last
  task automatic t_types;
    tx_ready = 4'h0;
    wr(6'h23, 8'h02);
    timer_event = 2'h2;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h17);
    wr(6'h21, 8'h01);
    timer_event = 2'h1;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h15);
    wr(6'h20, 8'hC0);
    break_change = 4'h1;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h10);
    wr(6'h23, 8'h1E);
    state_change = 4'h8;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h07);
    rx_count = 12'h007;
    rx_error = 4'h1;
    rx_ready = 4'h1;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'hFC);
    wr(6'h2C, 8'hFC);
    irq_chk(1'b0);
    {rx_ready, break_change, state_change} = 12'h000;
    timer_event = 2'h0;
    wr(6'h2A, 8'h00);
    rd_chk(6'h28, 8'h00);
    rd_chk(6'h29, 8'h00);
  endtask

  // clock at 40 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // hang guard well beyond the expected run length
  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    fails = 0;
    checks = 0;
    nrst = 1'b0;
    {rx_ready, rx_error, tx_ready, break_change, state_change} = 20'h00000;
    timer_event = 2'h0;
    rx_count = 12'h000;
    tx_space = 12'h000;
    rx_data = 32'h00000000;
    repeat (6) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    t_reset();
    t_rx();
    t_styles();
    t_tx();
    t_types();
    print_verdict();
  end
endmodule // quad_uart_interrupt_front_end_test
